/* File: core/idm_map.svh */
/*
 * Constants of the internal data memory: offsets, field positions,
 * reset values and the program space limits.
 * Assumes inclusion by bare name from the package; the core module does not include it.
 */
`ifndef IDM_MAP_SVH
`define IDM_MAP_SVH

// ==========================================================
// data space
`define IDM_DEPTH 256
`define IDM_LOWER_TOP 8'h7F
`define IDM_UPPER_BIT 7
`define IDM_BIT_BASE 8'h20
`define IDM_BANK_REGS 8

// ==========================================================
// stack pointer register
`define IDM_STACK_PTR_OFS 8'h81
`define IDM_STACK_PTR_RST 8'h07
`define IDM_STACK_STEP 8'h01

// ==========================================================
// status byte and program store control fields
`define IDM_BANK_LOW_POS 3
`define IDM_BANK_HIGH_POS 4
`define IDM_PROG_WREN_POS 0

// ==========================================================
// program space
`define IDM_PROG_LAST_OK 16'hFBFF

`endif

/* File: core/idm_pkg.sv */
/*
 * Types of the internal data memory: access kinds and the packed
 * request and routing records.
 * Assumes idm_map.svh sits in the include path.
 */
`include "idm_map.svh"

package idm_pkg;

	// ==========================================================
	// access kinds, chosen by the core from the instruction type
	typedef enum logic [2:0] {
		OP_DIRECT = 3'b000,
		OP_INDIRECT = 3'b001,
		OP_BIT = 3'b010,
		OP_BANK_REG = 3'b011,
		OP_PUSH = 3'b100,
		OP_POP = 3'b101
	} op_type;

	typedef struct packed {
		op_type op;
		logic write;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wbit;
	} req_type;

	typedef struct packed {
		logic valid;
		logic write;
		logic bit_access;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wbit;
	} fn_space_type;

	typedef struct packed {
		logic ext_move;
		logic write;
		logic [15:0] addr;
		logic [7:0] wdata;
	} code_req_type;

endpackage : idm_pkg

/* File: core/internal_data_memory_map.sv */
/*
 * Internal 256-byte data memory with its address decode, working
 * register banks, bit region, stack pointer and program write gate.
 * Assumes the core issues at most one request per enabled cycle and
 * supplies the status byte and program store control byte itself.
 */
`timescale 1ns/100ps

module internal_data_memory_map
	import idm_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic req_valid,
	input wire req_type req,
	input wire logic [7:0] processor_status_byte,
	input wire logic [7:0] program_store_control,
	input wire logic code_req_valid,
	input wire code_req_type code_req,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_bit,
	output fn_space_type fn_space,
	output logic [7:0] stack_top_pointer,
	output logic code_wr_en,
	output logic [15:0] code_wr_addr,
	output logic [7:0] code_wr_data,
	output logic code_reserved
);

	// ==========================================================
	// storage
	logic [7:0] mem_q [`IDM_DEPTH];
	logic [7:0] stack_top_pointer_q;
	logic [1:0] bank_sel;
	logic [7:0] ptr;
	logic [7:0] ea;
	logic [7:0] byte_old;
	logic [7:0] byte_new;
	logic to_fn_space;
	logic to_stack_reg;
	logic ram_write;
	logic [2:0] bit_pos;

	assign bank_sel = {processor_status_byte[`IDM_BANK_HIGH_POS],
		processor_status_byte[`IDM_BANK_LOW_POS]};

	assign ptr = mem_q[{3'h0, bank_sel, 2'h0, req.addr[0]}];

	// ==========================================================
	// address decode
	always_comb begin
		ea = req.addr;
		to_fn_space = 1'b0;
		to_stack_reg = 1'b0;
		bit_pos = req.addr[2:0];
		unique case (req.op)
			OP_DIRECT: begin
				to_stack_reg = (req.addr == `IDM_STACK_PTR_OFS);
				// direct high goes out
				// the stack pointer is served here, never routed out
				to_fn_space = req.addr[`IDM_UPPER_BIT] &&
					!to_stack_reg;
			end
			OP_INDIRECT: ea = ptr;
			OP_BIT: begin
				ea = `IDM_BIT_BASE + {4'h0, req.addr[6:3]};
				to_fn_space = req.addr[`IDM_UPPER_BIT];
			end
			OP_BANK_REG: ea = {3'h0, bank_sel, req.addr[2:0]};
			OP_PUSH: ea = stack_top_pointer_q + `IDM_STACK_STEP;
			OP_POP: ea = stack_top_pointer_q;
			default: ea = req.addr;
		endcase
	end

	always_comb begin
		byte_old = mem_q[ea];
		byte_new = req.wdata;
		if (req.op == OP_BIT) begin
			byte_new = byte_old;
			byte_new[bit_pos] = req.wbit;
		end
	end

	assign ram_write = req_valid && !to_fn_space && !to_stack_reg &&
		(req.write || req.op == OP_PUSH) && req.op != OP_POP;

	// ==========================================================
	// RAM array, no reset: contents are undefined until written
	// full 256-byte array
	always_ff @(posedge clk) begin
		if (ce && ram_write) begin
			mem_q[ea] <= byte_new;
		end
	end

	// ==========================================================
	// stack pointer
	// no guard keeps the stack off the bank registers; placing
	// it clear of them is left to the software
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stack_top_pointer_q <= `IDM_STACK_PTR_RST;
		end else if (ce && req_valid) begin
			if (req.op == OP_PUSH) begin
				stack_top_pointer_q <= stack_top_pointer_q +
					`IDM_STACK_STEP;
			end else if (req.op == OP_POP) begin
				stack_top_pointer_q <= stack_top_pointer_q -
					`IDM_STACK_STEP;
			end else if (to_stack_reg && req.write) begin
				stack_top_pointer_q <= req.wdata;
			end
		end
	end

	assign stack_top_pointer = stack_top_pointer_q;

	// ==========================================================
	// answer to the core
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
			rsp_bit <= 1'b0;
		end else if (ce) begin
			rsp_valid <= req_valid;
			if (req_valid) begin
				// function space data comes back from outside
				rsp_data <= to_fn_space ? 8'h00 :
					(to_stack_reg ? stack_top_pointer_q : byte_old);
				rsp_bit <= to_fn_space ? 1'b0 : byte_old[bit_pos];
			end
		end
	end

	// ==========================================================
	// routing to special function space
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fn_space <= '0;
		end else if (ce) begin
			fn_space.valid <= req_valid && to_fn_space;
			if (req_valid && to_fn_space) begin
				fn_space.write <= req.write;
				fn_space.bit_access <= (req.op == OP_BIT);
				fn_space.addr <= req.addr;
				fn_space.wdata <= req.wdata;
				fn_space.wbit <= req.wbit;
			end
		end
	end

	// ==========================================================
	// program memory write gate
	logic code_ok;
	logic code_hi;

	assign code_hi = code_req.addr > `IDM_PROG_LAST_OK;
	assign code_ok = code_req_valid && code_req.write &&
		code_req.ext_move && !code_hi &&
		program_store_control[`IDM_PROG_WREN_POS];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			code_wr_en <= 1'b0;
			code_wr_addr <= 16'h0000;
			code_wr_data <= 8'h00;
			code_reserved <= 1'b0;
		end else if (ce) begin
			code_wr_en <= code_ok;
			code_reserved <= code_req_valid && code_hi;
			if (code_ok) begin
				code_wr_addr <= code_req.addr;
				code_wr_data <= code_req.wdata;
			end
		end
	end

	// ==========================================================
	// checks
	// expectations rebuilt from the request and bank_sel, not from address decode nets
	logic go;
	assign go = ce && req_valid;

	AST_STACK_RESET: assert property (@(posedge clk)
		rst |=> stack_top_pointer == `IDM_STACK_PTR_RST)
		else $error("stack pointer not at reset value");

	AST_PUSH_STEP: assert property (@(posedge clk)
		disable iff (rst)
		go && req.op == OP_PUSH |=>
		stack_top_pointer == $past(stack_top_pointer_q) + 8'h01 &&
		mem_q[stack_top_pointer] == $past(req.wdata))
		else $error("push not stored above old pointer");

	AST_POP_STEP: assert property (@(posedge clk)
		disable iff (rst)
		go && req.op == OP_POP |=>
		stack_top_pointer == $past(stack_top_pointer_q) - 8'h01 &&
		rsp_data == $past(mem_q[stack_top_pointer_q]))
		else $error("pop order wrong");

	AST_SP_LOCAL: assert property (@(posedge clk)
		disable iff (rst)
		go && req.op == OP_DIRECT && req.addr == 8'h81 && !req.write |=>
		!fn_space.valid && rsp_data == $past(stack_top_pointer_q))
		else $error("stack pointer read routed out");

	AST_DIRECT_HIGH: assert property (@(posedge clk)
		disable iff (rst)
		go && req.op == OP_DIRECT && req.addr[7] &&
		req.addr != 8'h81 |=>
		fn_space.valid && fn_space.addr == $past(req.addr))
		else $error("direct high access not routed out");

	AST_UPPER_APART: assert property (@(posedge clk)
		disable iff (rst)
		go && req.op == OP_DIRECT && req.addr[7] && req.write &&
		req.addr != 8'h81 |=>
		mem_q[$past(req.addr)] == $past(mem_q[req.addr]))
		else $error("direct high write touched upper RAM");

	AST_DIRECT_LOW: assert property (@(posedge clk)
		disable iff (rst)
		go && req.op == OP_DIRECT && !req.addr[7] && !req.write |=>
		!fn_space.valid && rsp_data == $past(mem_q[req.addr]))
		else $error("direct low read missed RAM");

	AST_INDIRECT_RAM: assert property (@(posedge clk)
		disable iff (rst)
		go && req.op == OP_INDIRECT |=> !fn_space.valid &&
		rsp_data ==
		$past(mem_q[mem_q[{3'h0, bank_sel, 2'h0, req.addr[0]}]]))
		else $error("indirect access left RAM");

	AST_BANK_READ: assert property (@(posedge clk)
		disable iff (rst)
		go && req.op == OP_BANK_REG && !req.write |=>
		rsp_data == $past(mem_q[{3'h0, bank_sel, req.addr[2:0]}]))
		else $error("bank register read from wrong bank");

	AST_BANK_WRITE: assert property (@(posedge clk)
		disable iff (rst)
		go && req.op == OP_BANK_REG && req.write |=>
		mem_q[{3'h0, $past(bank_sel), $past(req.addr[2:0])}] ==
		$past(req.wdata))
		else $error("bank register write landed elsewhere");

	AST_BIT_READ: assert property (@(posedge clk)
		disable iff (rst)
		go && req.op == OP_BIT && !req.addr[7] |=>
		rsp_bit == $past(mem_q[8'h20 + {4'h0, req.addr[6:3]}]
		[req.addr[2:0]]))
		else $error("bit read from wrong location");

	AST_BIT_WRITE: assert property (@(posedge clk)
		disable iff (rst)
		go && req.op == OP_BIT && req.write && !req.addr[7] |=>
		mem_q[8'h20 + {4'h0, $past(req.addr[6:3])}]
		[$past(req.addr[2:0])] == $past(req.wbit))
		else $error("bit write missed its bit");

	AST_PROG_GATE: assert property (@(posedge clk)
		disable iff (rst)
		ce && code_req_valid && code_req.write &&
		(!program_store_control[0] || !code_req.ext_move) |=>
		!code_wr_en)
		else $error("program write without enable");

	AST_PROG_GRANT: assert property (@(posedge clk)
		disable iff (rst)
		ce && code_req_valid && code_req.write && code_req.ext_move &&
		program_store_control[0] && code_req.addr <= 16'hFBFF |=>
		code_wr_en && code_wr_addr == $past(code_req.addr) &&
		code_wr_data == $past(code_req.wdata))
		else $error("enabled program write not granted");

	AST_PROG_RESERVED: assert property (@(posedge clk)
		disable iff (rst)
		ce && code_req_valid && code_req.addr > 16'hFBFF |=>
		code_reserved && !code_wr_en)
		else $error("reserved program address accepted");

	AST_RSP_QUIET: assert property (@(posedge clk)
		disable iff (rst)
		ce && !req_valid |=> !rsp_valid && !fn_space.valid)
		else $error("answer without a request");

	AST_FREEZE: assert property (@(posedge clk)
		disable iff (rst)
		!ce |=> stack_top_pointer == $past(stack_top_pointer_q) &&
		rsp_valid == $past(rsp_valid) && fn_space == $past(fn_space))
		else $error("state moved while clock enable low");

	COV_PUSH: cover property (@(posedge clk) disable iff (rst)
		go && req.op == OP_PUSH ##1 go && req.op == OP_POP);
	COV_UPPER: cover property (@(posedge clk) disable iff (rst)
		go && req.op == OP_INDIRECT && ptr[7]);
	COV_BIT_WRITE: cover property (@(posedge clk) disable iff (rst)
		go && req.op == OP_BIT && req.write && !req.addr[7]);
	COV_SP_WRAP: cover property (@(posedge clk) disable iff (rst)
		go && req.op == OP_PUSH && stack_top_pointer_q == 8'hFF);
	COV_BANK_THREE: cover property (@(posedge clk) disable iff (rst)
		go && req.op == OP_BANK_REG && bank_sel == 2'h3);

endmodule : internal_data_memory_map

/* File: test/core_status_model.sv */
/*
 * Core side model: owns the status byte and the program store control.
 * Assumes the clock and reset of the internal data memory block.
 */
`timescale 1ns/100ps

module core_status_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] bank_sel,
	input wire logic prog_wren,
	output logic [7:0] processor_status_byte,
	output logic [7:0] program_store_control
);
	// ==========================================================
	// status byte
	// bank bits four and three
	// noise in the other bits catches a wrong field decode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			processor_status_byte <= 8'h00;
		end else begin
			processor_status_byte <= {3'h5, bank_sel, 3'h5};
		end
	end

	// ==========================================================
	// program store control
	// write enable bit zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			program_store_control <= 8'h00;
		end else begin
			program_store_control <= {7'h2A, prog_wren};
		end
	end
endmodule : core_status_model

/* File: test/internal_data_memory_map_bench.sv */
/*
 * Self-checking bench of the internal data memory map.
 * Assumes a one cycle answer to each request, as the block promises.
 */
`timescale 1ns/100ps

module internal_data_memory_map_bench;
	import idm_pkg::*;
	logic clk, rst, ce, req_valid, code_req_valid, prog_wren;
	logic [1:0] bank_sel;
	req_type req;
	code_req_type code_req;
	logic [7:0] psb, psc, rsp_data, stack_top_pointer, code_wr_data;
	logic rsp_valid, rsp_bit, code_wr_en, code_reserved;
	logic [15:0] code_wr_addr;
	fn_space_type fn_space;
	int err_count, checks;

	core_status_model core (.clk(clk), .rst(rst), .bank_sel(bank_sel),
		.prog_wren(prog_wren), .processor_status_byte(psb),
		.program_store_control(psc));

	internal_data_memory_map dut (.clk(clk), .rst(rst), .ce(ce),
		.req_valid(req_valid), .req(req), .processor_status_byte(psb),
		.program_store_control(psc), .code_req_valid(code_req_valid),
		.code_req(code_req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_bit(rsp_bit), .fn_space(fn_space),
		.stack_top_pointer(stack_top_pointer), .code_wr_en(code_wr_en),
		.code_wr_addr(code_wr_addr), .code_wr_data(code_wr_data),
		.code_reserved(code_reserved));

	always #5 clk = ~clk;

	// ==========================================================
	// shared tasks
	task automatic chk(input string n, input logic [15:0] e, g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// strobe stays up so back to back requests never clash
	task automatic acc(input op_type op, input logic w,
			input logic [7:0] a, d, input logic b);
		req_valid = 1'b1;
		req = '{op: op, write: w, addr: a, wdata: d, wbit: b};
		@(negedge clk);
		chk("rsp_valid", 16'h0001, {15'h0000, rsp_valid});
	endtask : acc

	task automatic cd(input logic x, input logic [15:0] a);
		code_req_valid = 1'b1;
		code_req = '{ext_move: x, write: 1'b1, addr: a, wdata: 8'h5C};
		@(negedge clk);
	endtask : cd

	task automatic set_core(input logic [1:0] b, input logic w);
		req_valid = 1'b0;
		code_req_valid = 1'b0;
		bank_sel = b;
		prog_wren = w;
		@(negedge clk);
	endtask : set_core

	task automatic done(input string n);
		req_valid = 1'b0;
		code_req_valid = 1'b0;
		@(negedge clk);
		$display("test %s done", n);
	endtask : done

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict

	// ==========================================================
	// scenarios
	task automatic t_reset;
		chk("sp", 16'h0007, stack_top_pointer);
		acc(OP_DIRECT, 1'b0, 8'h81, 8'h00, 1'b0);
		chk("sp_read", 16'h0007, rsp_data);
		done("reset");
	endtask : t_reset

	task automatic t_stack;
		acc(OP_PUSH, 1'b1, 8'h00, 8'hAA, 1'b0);
		chk("sp_push", 16'h0008, stack_top_pointer);
		acc(OP_DIRECT, 1'b0, 8'h08, 8'h00, 1'b0);
		chk("first_push", 16'h00AA, rsp_data);
		acc(OP_POP, 1'b1, 8'h00, 8'h00, 1'b0);
		chk("pop_data", 16'h00AA, rsp_data);
		chk("sp_pop", 16'h0007, stack_top_pointer);
		acc(OP_DIRECT, 1'b1, 8'h81, 8'hFF, 1'b0);
		acc(OP_PUSH, 1'b1, 8'h00, 8'h3C, 1'b0);
		chk("sp_wrap", 16'h0000, stack_top_pointer);
		acc(OP_DIRECT, 1'b0, 8'h00, 8'h00, 1'b0);
		chk("wrap_data", 16'h003C, rsp_data);
		done("stack");
	endtask : t_stack

	task automatic t_banks;
		for (int b = 0; b < 4; b++) begin
			set_core(2'(b), 1'b0);
			acc(OP_BANK_REG, 1'b1, 8'h01, 8'(8'h40 + b), 1'b0);
		end
		set_core(2'h0, 1'b0);
		for (int b = 0; b < 4; b++) begin
			acc(OP_DIRECT, 1'b0, 8'(b * 8 + 1), 8'h00, 1'b0);
			chk("bank_reg", 16'(8'h40 + b), rsp_data);
		end
		done("banks");
	endtask : t_banks

	task automatic t_indirect;
		set_core(2'h2, 1'b0);
		acc(OP_BANK_REG, 1'b1, 8'h00, 8'h90, 1'b0);
		acc(OP_INDIRECT, 1'b1, 8'h00, 8'h5A, 1'b0);
		acc(OP_DIRECT, 1'b1, 8'h90, 8'hC3, 1'b0);
		chk("fn_valid", 16'h0001, {15'h0000, fn_space.valid});
		chk("fn_addr", 16'h0090, fn_space.addr);
		chk("fn_write", 16'h0001, {15'h0000, fn_space.write});
		chk("fn_wdata", 16'h00C3, fn_space.wdata);
		acc(OP_INDIRECT, 1'b0, 8'h00, 8'h00, 1'b0);
		chk("upper_ram", 16'h005A, rsp_data);
		acc(OP_BANK_REG, 1'b1, 8'h01, 8'h30, 1'b0);
		acc(OP_INDIRECT, 1'b1, 8'h01, 8'h77, 1'b0);
		acc(OP_DIRECT, 1'b0, 8'h30, 8'h00, 1'b0);
		chk("lower_ram", 16'h0077, rsp_data);
		chk("fn_idle", 16'h0000, {15'h0000, fn_space.valid});
		done("indirect");
	endtask : t_indirect

	task automatic t_bits;
		acc(OP_DIRECT, 1'b1, 8'h22, 8'h00, 1'b0);
		acc(OP_BIT, 1'b1, 8'h13, 8'h00, 1'b1);
		acc(OP_DIRECT, 1'b0, 8'h22, 8'h00, 1'b0);
		chk("bit_byte", 16'h0008, rsp_data);
		acc(OP_BIT, 1'b0, 8'h13, 8'h00, 1'b0);
		chk("bit_read", 16'h0001, {15'h0000, rsp_bit});
		acc(OP_DIRECT, 1'b1, 8'h2F, 8'h80, 1'b0);
		acc(OP_BIT, 1'b0, 8'h7F, 8'h00, 1'b0);
		chk("bit_top", 16'h0001, {15'h0000, rsp_bit});
		acc(OP_BIT, 1'b1, 8'h85, 8'h00, 1'b1);
		chk("fn_bit", 16'h0001, {15'h0000, fn_space.bit_access});
		chk("fn_wbit", 16'h0001, {15'h0000, fn_space.wbit});
		done("bits");
	endtask : t_bits

	task automatic t_code;
		set_core(2'h0, 1'b1);
		cd(1'b1, 16'h1000);
		chk("wr_en", 16'h0001, {15'h0000, code_wr_en});
		chk("wr_addr", 16'h1000, code_wr_addr);
		chk("wr_data", 16'h005C, code_wr_data);
		cd(1'b0, 16'h1001);
		chk("no_move", 16'h0000, {15'h0000, code_wr_en});
		cd(1'b1, 16'hFC00);
		chk("rsvd_wr", 16'h0000, {15'h0000, code_wr_en});
		chk("rsvd", 16'h0001, {15'h0000, code_reserved});
		cd(1'b1, 16'hFBFF);
		chk("last_ok", 16'h0000, {15'h0000, code_reserved});
		set_core(2'h0, 1'b0);
		cd(1'b1, 16'h1002);
		chk("no_wren", 16'h0000, {15'h0000, code_wr_en});
		done("code");
	endtask : t_code

	// clock enable low holds everything, then a reset in mid-run
	task automatic t_freeze;
		acc(OP_DIRECT, 1'b0, 8'h81, 8'h00, 1'b0);
		chk("sp_read2", 16'h0000, rsp_data);
		ce = 1'b0;
		req = '{op: OP_PUSH, write: 1'b1, addr: 8'h00, wdata: 8'h11,
			wbit: 1'b0};
		@(negedge clk);
		chk("sp_frozen", 16'h0000, stack_top_pointer);
		chk("rsp_held", 16'h0001, {15'h0000, rsp_valid});
		ce = 1'b1;
		req_valid = 1'b0;
		@(negedge clk);
		rst = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		chk("sp_rerst", 16'h0007, stack_top_pointer);
		chk("rsp_rerst", 16'h0000, {15'h0000, rsp_valid});
		done("freeze");
	endtask : t_freeze

	// ==========================================================
	// main sequence and hang guard
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		ce = 1'b1;
		req_valid = 1'b0;
		req = '0;
		code_req_valid = 1'b0;
		code_req = '0;
		bank_sel = 2'h0;
		prog_wren = 1'b0;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_stack();
		t_banks();
		t_indirect();
		t_bits();
		t_code();
		t_freeze();
		give_verdict();
	end

	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		$display("BAD run_length expected end seen hang");
		give_verdict();
	end
endmodule : internal_data_memory_map_bench
